// ---- hdl/dls_core.sv ----
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module dls_core #(
	parameter int TICK_CYCLES = dls_pkg::TICK_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic [1:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic      [7:0]         reg_rdata,
	input  wire dls_pkg::dls_tones_s tones_pin,
	input  wire logic               detect_supported,
	input  wire logic               incoming_message_recording,
	input  wire logic               recall_press,
	input  wire logic               recall_is_earth,
	input  wire logic               line_seized,
	input  wire logic               dialing_done,
	input  wire logic               auto_sending,
	input  wire logic               auto_receiving,
	input  wire logic               pulse_dialing,
	input  wire logic               pause_press,
	input  wire logic               remote_digit,
	output logic                    earth_menu_offered,
	output logic                    icm_high_sensitivity,
	output logic                    line_release,
	output logic                    line_wire_a_earth,
	output logic                    line_break,
	output logic                    dial_start,
	output logic                    remote_id_valid,
	output logic                    dtmf_valid,
	output logic                    pause_active,
	output logic                    pause_done
);
	typedef enum {D_IDLE, D_WAIT, D_DETECT} dls_dial_e;
	typedef enum {P_IDLE, P_WAIT, P_TONE, P_POST} dls_pause_e;

	logic [7:0]          xfer_sw;
	logic [7:0]          dial_sw;
	logic [7:0]          pause_sw;
	logic [5:0]          s1;
	logic [5:0]          s2;
	logic [5:0]          s3;
	dls_pkg::dls_tones_s tn;
	logic [16:0]         div_cnt;
	logic                tick;
	dls_pkg::dls_ms_t    recall_cnt;
	dls_pkg::dls_ms_t    dial_cnt;
	dls_pkg::dls_ms_t    dial_target;
	dls_dial_e           dial_st;
	logic                release_cond;
	logic                release_prev;
	logic                first_seen;
	dls_pkg::dls_ms_t    gap_cnt;
	dls_pkg::dls_ms_t    dtmf_cnt;
	dls_pause_e          pause_st;
	dls_pkg::dls_ms_t    pause_cnt;
	dls_pkg::dls_ms_t    pause_target;
	dls_pkg::dls_ms_t    run_cnt;
	dls_pkg::dls_ms_t    brk_cnt;
	logic                armed;
	logic                hits;
	logic [2:0]          dial_code;
	logic [2:0]          pause_code;
	logic                pair_hit;
	logic                busy_send;
	logic                busy_recv;
	dls_pkg::dls_ms_t    gap_limit;
	dls_pkg::dls_ms_t    brk_limit;
	logic                tone_long;

	// software writes to the switch bytes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			xfer_sw  <= dls_pkg::SW_RESET;
			dial_sw  <= dls_pkg::SW_RESET;
			pause_sw <= dls_pkg::SW_RESET;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				dls_pkg::ADDR_XFER:  xfer_sw  <= reg_wdata;
				dls_pkg::ADDR_DIAL:  dial_sw  <= reg_wdata;
				dls_pkg::ADDR_PAUSE: pause_sw <= reg_wdata;
				default:             ;
			endcase
		end
	end

	// read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
				dls_pkg::ADDR_XFER:  reg_rdata <= xfer_sw;
				dls_pkg::ADDR_DIAL:  reg_rdata <= dial_sw;
				dls_pkg::ADDR_PAUSE: reg_rdata <= pause_sw;
				default:             reg_rdata <= {1'b0, hits, first_seen,
					dial_st != D_IDLE, pause_active, dtmf_valid,
					line_break, line_wire_a_earth};
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// three-stage synchronisers, value taken once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_sync
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
				begin
					s1[gi] <= 1'b0;
					s2[gi] <= 1'b0;
					s3[gi] <= 1'b0;
					tn[gi] <= 1'b0;
				end
				else
				begin
					s1[gi] <= tones_pin[gi];
					s2[gi] <= s1[gi];
					s3[gi] <= s2[gi];
					if (s2[gi] == s3[gi])
						tn[gi] <= s3[gi];
				end
			end
		end
	endgenerate

	// common millisecond tick
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt <= 17'h00000;
			tick    <= 1'b0;
		end
		else if (div_cnt == 17'(TICK_CYCLES - 1))
		begin
			div_cnt <= 17'h00000;
			tick    <= 1'b1; // RULE19
		end
		else
		begin
			div_cnt <= div_cnt + 17'h00001;
			tick    <= 1'b0;
		end
	end

	// decoded switch fields
	assign dial_code  = {dial_sw[dls_pkg::FD_WAIT], dial_sw[dls_pkg::FD_WAIT + 1],
		dial_sw[dls_pkg::FD_WAIT + 2]};
	assign pause_code = {pause_sw[dls_pkg::PS_MODE], pause_sw[dls_pkg::PS_MODE + 1],
		pause_sw[dls_pkg::PS_MODE + 2]};
	assign gap_limit  = dial_sw[dls_pkg::FD_GAP] ? dls_pkg::GAP_SHORT_MS
		: dls_pkg::GAP_LONG_MS; // RULE10
	assign brk_limit  = pause_sw[dls_pkg::PS_BREAK] ? dls_pkg::BRK_LONG_MS
		: dls_pkg::BRK_SHORT_MS; // RULE18

	// static option outputs
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			earth_menu_offered   <= 1'b0;
			icm_high_sensitivity <= 1'b0;
		end
		else
		begin
			earth_menu_offered   <= ~xfer_sw[dls_pkg::XF_EARTH_OFF]; // RULE1
			icm_high_sensitivity <= xfer_sw[dls_pkg::XF_SENS]; // RULE3
		end
	end

	// line release causes: recording tone pair and busy tone
	always_comb
	begin
		case ({xfer_sw[dls_pkg::XF_FREQ], xfer_sw[dls_pkg::XF_FREQ + 1]})
			2'h0:    pair_hit = tn.pair_350_440; // RULE2
			2'h1:    pair_hit = tn.pair_440_480;
			default: pair_hit = tn.pair_480_620;
		endcase
		busy_send = auto_sending & tn.busy_tone & dial_sw[dls_pkg::FD_BUSY + 1]
			& (dial_sw[dls_pkg::FD_BUSY] | dialing_done); // RULE11
		busy_recv = auto_receiving & tn.busy_tone & ~dial_sw[dls_pkg::FD_RECV]; // RULE12
		release_cond = (incoming_message_recording & pair_hit) | busy_send | busy_recv;
	end

	// one release pulse per rise of the combined causes
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			release_prev <= 1'b0;
			line_release <= 1'b0;
		end
		else
		begin
			release_prev <= release_cond;
			line_release <= release_cond & ~release_prev; // RULE2
		end
	end

	// recall key: earth short or flash break for the chosen time
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			recall_cnt        <= 15'h0000;
			line_wire_a_earth <= 1'b0;
			line_break        <= 1'b0;
		end
		else if (recall_press && !line_wire_a_earth && !line_break)
		begin
			line_wire_a_earth <= recall_is_earth; // RULE4
			line_break        <= ~recall_is_earth; // RULE6
			recall_cnt        <= recall_is_earth
				? dls_pkg::earth_ms({xfer_sw[dls_pkg::XF_EARTH_T],
					xfer_sw[dls_pkg::XF_EARTH_T + 1]}) // RULE5
				: dls_pkg::flash_ms({xfer_sw[dls_pkg::XF_FLASH_T],
					xfer_sw[dls_pkg::XF_FLASH_T + 1]}); // RULE7
		end
		else if (tick && recall_cnt != 15'h0000)
			recall_cnt <= recall_cnt - 15'h0001;
		else if (recall_cnt == 15'h0000)
		begin
			line_wire_a_earth <= 1'b0;
			line_break        <= 1'b0;
		end
	end

	// first dial tone: fixed wait or detection after seizure
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dial_st     <= D_IDLE;
			dial_cnt    <= 15'h0000;
			dial_target <= 15'h0000;
			dial_start  <= 1'b0;
		end
		else
		begin
			dial_start <= 1'b0;
			case (dial_st)
				D_IDLE:
					if (line_seized)
					begin
						dial_cnt <= 15'h0000;
						if (dial_code == 3'h7 && detect_supported)
							dial_st <= D_DETECT; // RULE8
						else
						begin
							dial_st     <= D_WAIT;
							dial_target <= (dial_code == 3'h7) ? dls_pkg::WAIT_STEP_MS // RULE9
								: 15'(({12'h000, dial_code} + 15'h0001)
									* dls_pkg::WAIT_STEP_MS); // RULE8
						end
					end
				D_WAIT:
					if (dial_cnt >= dial_target)
					begin
						dial_start <= 1'b1;
						dial_st    <= D_IDLE;
					end
					else if (tick)
						dial_cnt <= dial_cnt + 15'h0001;
				D_DETECT:
					if (tn.dial_tone)
					begin
						dial_start <= 1'b1; // RULE8
						dial_st    <= D_IDLE;
					end
				default: dial_st <= D_IDLE;
			endcase
		end
	end

	// remote ID: second digit must follow within the gap
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			first_seen      <= 1'b0;
			gap_cnt         <= 15'h0000;
			remote_id_valid <= 1'b0;
		end
		else
		begin
			remote_id_valid <= 1'b0;
			if (remote_digit)
			begin
				remote_id_valid <= first_seen; // RULE10
				first_seen      <= ~first_seen;
				gap_cnt         <= 15'h0000;
			end
			else if (first_seen && tick)
			begin
				if (gap_cnt >= gap_limit)
					first_seen <= 1'b0; // RULE10
				else
					gap_cnt <= gap_cnt + 15'h0001;
			end
		end
	end

	// DTMF tone must last the minimum time
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dtmf_cnt   <= 15'h0000;
			dtmf_valid <= 1'b0;
		end
		else if (!tn.dtmf_tone)
		begin
			dtmf_cnt   <= 15'h0000;
			dtmf_valid <= 1'b0;
		end
		else
		begin
			if (tick && dtmf_cnt != 15'h7FFF)
				dtmf_cnt <= dtmf_cnt + 15'h0001;
			dtmf_valid <= dtmf_cnt >= (dial_sw[dls_pkg::FD_DTMF]
				? dls_pkg::DTMF_LONG_MS : dls_pkg::DTMF_SHORT_MS); // RULE13
		end
	end

	assign tone_long = run_cnt >= dls_pkg::intl_ms({pause_sw[dls_pkg::PS_INTL],
		pause_sw[dls_pkg::PS_INTL + 1], pause_sw[dls_pkg::PS_INTL + 2]}); // RULE16

	// pause key: plain wait or second dial tone detection
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pause_st     <= P_IDLE;
			pause_cnt    <= 15'h0000;
			pause_target <= 15'h0000;
			run_cnt      <= 15'h0000;
			brk_cnt      <= 15'h0000;
			armed        <= 1'b0;
			hits         <= 1'b0;
			pause_done   <= 1'b0;
		end
		else
		begin
			pause_done <= 1'b0;
			case (pause_st)
				P_IDLE:
					if (pause_press)
					begin
						pause_cnt <= 15'h0000;
						run_cnt   <= 15'h0000;
						brk_cnt   <= 15'h0000;
						armed     <= 1'b1;
						hits      <= 1'b0;
						if (pause_code == 3'h0)
							pause_done <= 1'b1; // RULE14
						else if (pause_code <= 3'h4)
						begin
							pause_st     <= P_WAIT;
							pause_target <= 15'({12'h000, pause_code}
								* dls_pkg::WAIT_STEP_MS); // RULE14
						end
						else if (!detect_supported)
						begin
							pause_st     <= P_WAIT;
							pause_target <= dls_pkg::WAIT_STEP_MS;
						end
						else if (pause_code == 3'h6 && !pulse_dialing)
							pause_done <= 1'b1; // RULE15
						else
							pause_st <= P_TONE; // RULE15
					end
				P_WAIT, P_POST:
					if (pause_cnt >= pause_target)
					begin
						pause_done <= 1'b1;
						pause_st   <= P_IDLE;
					end
					else if (tick)
						pause_cnt <= pause_cnt + 15'h0001;
				P_TONE:
					if (armed && tone_long)
					begin
						run_cnt <= 15'h0000;
						armed   <= 1'b0;
						hits    <= 1'b1;
						if (hits || !pause_sw[dls_pkg::PS_TWICE]) // RULE17
						begin
							pause_cnt    <= 15'h0000;
							pause_target <= dls_pkg::WAIT_STEP_MS;
							pause_st     <= (pause_code == 3'h5) ? P_WAIT : P_POST;
						end
					end
					else if (tick)
					begin
						if (tn.dial_tone)
						begin
							brk_cnt <= 15'h0000;
							if (armed)
								run_cnt <= run_cnt + 15'h0001;
						end
						else if (brk_cnt >= brk_limit)
						begin
							run_cnt <= 15'h0000; // RULE18
							armed   <= 1'b1;
						end
						else
							brk_cnt <= brk_cnt + 15'h0001;
					end
				default: pause_st <= P_IDLE;
			endcase
		end
	end

	assign pause_active = pause_st != P_IDLE;
endmodule : dls_core

// ---- hdl/dls_pkg.sv ----
// Functional notes
// (RULE1) transfer bit 1 offers earth in menu; the code offers it only while bit 1 is low
// (RULE2) line release on chosen tone pair during recording
// (RULE3) transfer bit 4 raises recording tone sensitivity
// (RULE4) bits 5-6 set earth time, earth key only
// (RULE5) earth codes give 200/300/500/700 ms
// (RULE6) bits 7-8 set flash break, flash key only
// (RULE7) flash codes give 80/110/250/500 ms
// (RULE8) code 111 detects dial tone, else fixed wait
// (RULE9) unsupported detection makes 111 wait 3.5 s
// (RULE10) remote ID second digit within 2 s/1 s
// (RULE11) sending busy tone: ignore, after, or both
// (RULE12) receiving busy tone releases line when bit low
// (RULE13) DTMF minimum 40 ms or 100 ms
// (RULE14) pause key waits none, 3.5 to 14 s
// (RULE15) second tone detection: 110 pulse only, 101/111 both
// (RULE16) international tone duration from eight codes
// (RULE17) second tone needed once or twice
// (RULE18) tolerated tone break 30 or 50 ms
// (RULE19) all timing from one millisecond tick
package dls_pkg;
	// register addresses
	localparam logic [1:0] ADDR_XFER  = 2'h0;
	localparam logic [1:0] ADDR_DIAL  = 2'h1;
	localparam logic [1:0] ADDR_PAUSE = 2'h2;
	localparam logic [1:0] ADDR_STAT  = 2'h3;
	localparam logic [7:0] SW_RESET   = 8'h00;
	// field positions, first selector is bit 0 and the code msb
	localparam int XF_EARTH_OFF = 0;
	localparam int XF_FREQ      = 1;
	localparam int XF_SENS      = 3;
	localparam int XF_EARTH_T   = 4;
	localparam int XF_FLASH_T   = 6;
	localparam int FD_WAIT      = 0;
	localparam int FD_GAP       = 3;
	localparam int FD_BUSY      = 4;
	localparam int FD_RECV      = 6;
	localparam int FD_DTMF      = 7;
	localparam int PS_MODE      = 0;
	localparam int PS_INTL      = 3;
	localparam int PS_TWICE     = 6;
	localparam int PS_BREAK     = 7;
	// timebase
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_MS       = 1;
	localparam int TICK_CYCLES   = TICK_MS * 1000000 / CLK_PERIOD_NS;
	typedef logic [14:0] dls_ms_t;
	localparam dls_ms_t WAIT_STEP_MS  = 15'h0DAC;
	localparam dls_ms_t GAP_LONG_MS   = 15'h07D0;
	localparam dls_ms_t GAP_SHORT_MS  = 15'h03E8;
	localparam dls_ms_t DTMF_SHORT_MS = 15'h0028;
	localparam dls_ms_t DTMF_LONG_MS  = 15'h0064;
	localparam dls_ms_t BRK_SHORT_MS  = 15'h001E;
	localparam dls_ms_t BRK_LONG_MS   = 15'h0032;
	// detected tone pins
	typedef struct packed {
		logic pair_350_440;
		logic pair_440_480;
		logic pair_480_620;
		logic dial_tone;
		logic busy_tone;
		logic dtmf_tone;
	} dls_tones_s;

	function automatic dls_ms_t earth_ms(input logic [1:0] c);
		case (c)
			2'h0:    earth_ms = 15'h00C8;
			2'h1:    earth_ms = 15'h012C;
			2'h2:    earth_ms = 15'h01F4;
			default: earth_ms = 15'h02BC;
		endcase
	endfunction : earth_ms

	function automatic dls_ms_t flash_ms(input logic [1:0] c);
		case (c)
			2'h0:    flash_ms = 15'h0050;
			2'h1:    flash_ms = 15'h006E;
			2'h2:    flash_ms = 15'h00FA;
			default: flash_ms = 15'h01F4;
		endcase
	endfunction : flash_ms

	function automatic dls_ms_t intl_ms(input logic [2:0] c);
		case (c)
			3'h0:    intl_ms = 15'h0032;
			3'h1:    intl_ms = 15'h00D2;
			3'h2:    intl_ms = 15'h01F4;
			3'h3:    intl_ms = 15'h0320;
			3'h4:    intl_ms = 15'h0384;
			3'h5:    intl_ms = 15'h05DC;
			3'h6:    intl_ms = 15'h07D0;
			default: intl_ms = 15'h09C4;
		endcase
	endfunction : intl_ms
endpackage : dls_pkg

// ---- test/dls_core_props.sv ----
`timescale 1ns/100ps
module dls_core_props (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       recall_press,
	input wire logic       recall_is_earth,
	input wire logic       pause_press,
	input wire logic       earth_menu_offered,
	input wire logic       icm_high_sensitivity,
	input wire logic       line_release,
	input wire logic       line_wire_a_earth,
	input wire logic       line_break,
	input wire logic       dial_start,
	input wire logic       pause_active,
	input wire logic       pause_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [7:0] pause_sw;
	logic       idle_key;
	// shadow of the pause byte, so the checker knows the pause code
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			pause_sw <= 8'h00;
		else if (reg_wr && reg_addr == 2'h2)
			pause_sw <= reg_wdata;
	// a recall press that the block must take
	assign idle_key = recall_press && !line_wire_a_earth && !line_break;
	chk_menu_follow: assert property (
		reg_wr && reg_addr == 2'h0 |=> ##1 earth_menu_offered == !$past(reg_wdata[0], 2))
		else $error("earth menu flag wrong after write");
	chk_sens_follow: assert property (
		reg_wr && reg_addr == 2'h0 |=> ##1 icm_high_sensitivity == $past(reg_wdata[3], 2))
		else $error("sensitivity flag wrong after write");
	chk_earth_start: assert property (idle_key && recall_is_earth |=>
		line_wire_a_earth && !line_break) else $error("earth short did not start");
	chk_flash_start: assert property (idle_key && !recall_is_earth |=>
		line_break && !line_wire_a_earth) else $error("flash break did not start");
	chk_earth_hold: assert property ($rose(line_wire_a_earth) |->
		line_wire_a_earth[*8]) else $error("earth short too short");
	chk_break_hold: assert property ($rose(line_break) |-> line_break[*8])
		else $error("flash break too short");
	chk_release_pulse: assert property (line_release |=> !line_release)
		else $error("line release longer than one cycle");
	chk_dial_pulse: assert property (dial_start |=> !dial_start)
		else $error("dial start longer than one cycle");
	chk_pause_none: assert property (
		pause_press && !pause_active && pause_sw[2:0] == 3'h0 |=> pause_done ##1 !pause_done)
		else $error("pause code zero did not finish at once");
	chk_pause_wait: assert property (
		pause_press && !pause_active && pause_sw[2:0] == 3'h4 |=>
		(pause_active && !pause_done)[*8]) else $error("pause wait ended early");
endmodule : dls_core_props

bind dls_core dls_core_props dls_core_props_inst (.*);

// ---- test/dls_line_model.sv ----
`timescale 1ns/100ps
module dls_line_model (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire dls_pkg::dls_tones_s tone_req,
	output dls_pkg::dls_tones_s      tones_pin
);
	dls_pkg::dls_tones_s stage;
	// tone detectors answer two cycles late and stay silent in reset
	always_ff @(posedge clk or negedge rstn)
		if (!rstn)
			{tones_pin, stage} <= 12'h000;
		else
			{tones_pin, stage} <= {stage, tone_req};
endmodule : dls_line_model

// ---- test/dls_core_tb.sv ----
`timescale 1ns/100ps
module dls_core_tb;
	localparam int T = 4;
	logic clk, rstn, reg_wr, reg_rd, detect_supported, recall_is_earth, pulse_dialing;
	logic recall_press, line_seized, pause_press, remote_digit, dialing_done;
	logic incoming_message_recording, auto_sending, auto_receiving;
	logic earth_menu_offered, icm_high_sensitivity, line_release, line_wire_a_earth;
	logic line_break, dial_start, remote_id_valid, dtmf_valid, pause_active, pause_done;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] pl, md;
	dls_pkg::dls_tones_s tone_req, tones_pin;
	int n_fail = 0, check_count = 0, cyc = 0;
	wire [2:0] ev = {line_wire_a_earth, line_break, dial_start};
	// key pulses and line modes
	assign {recall_press, line_seized, pause_press, remote_digit} = pl;
	assign {incoming_message_recording, auto_sending, auto_receiving, dialing_done} = md;
	dls_core #(.TICK_CYCLES(T)) dls_core_inst (.*);
	dls_line_model dls_line_model_inst (.*);
	// free running clock
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'h1};
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 cmp(reg_rdata, e);
	endtask : rd
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		pl <= m;
		@(posedge clk);
		pl <= 4'h0;
		#1;
	endtask : pulse
	// counts cycles while the chosen output keeps level lv
	task automatic meas(input int b, input logic lv, input int lim, output int n);
		n = 0;
		while (ev[b] === lv && n < lim)
		begin
			@(posedge clk);
			#1 n++;
		end
	endtask : meas
	// one ms of tick quantisation plus synchroniser latency allowed
	task automatic near(input int n, input int e);
		cmp(n > e - T - 8 && n < e + T + 8, 1'h1);
	endtask : near
	task automatic t_regs();
		for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
		wr(2'h0, 8'hA5);
		wr(2'h1, 8'h5A);
		wr(2'h2, 8'hC3);
		wr(2'h3, 8'hFF);
		rd(2'h0, 8'hA5);
		rd(2'h1, 8'h5A);
		rd(2'h2, 8'hC3);
		rd(2'h3, 8'h00);
		cmp({earth_menu_offered, icm_high_sensitivity}, 2'h0);
		wr(2'h0, 8'h08);
		@(posedge clk);
		#1 cmp({earth_menu_offered, icm_high_sensitivity}, 2'h3);
	endtask : t_regs
	task automatic t_recall();
		int n;
		int ms[8] = '{200, 300, 500, 700, 80, 110, 250, 500};
		for (int i = 0; i < 8; i++)
		begin
			wr(2'h0, i < 4 ? {2'h0, i[0], i[1], 4'h0} : {i[0], i[1], 6'h00});
			recall_is_earth <= i < 4;
			pulse(4'h8);
			meas(i < 4 ? 2 : 1, 1'h1, 4000, n);
			near(n, ms[i] * T);
		end
	endtask : t_recall
	task automatic t_dial();
		int n;
		wr(2'h1, 8'h00);
		pulse(4'h4);
		meas(0, 1'h0, 20000, n);
		near(n, 3500 * T);
		wr(2'h1, 8'h07);
		detect_supported <= 1'h1;
		pulse(4'h4);
		meas(0, 1'h0, 60, n);
		cmp(n, 60);
		@(posedge clk);
		tone_req <= 6'h04;
		meas(0, 1'h0, 40, n);
		near(n, 6);
		@(posedge clk);
		{tone_req, detect_supported} <= 7'h00;
		pulse(4'h4);
		meas(0, 1'h0, 20000, n);
		near(n, 3500 * T);
	endtask : t_dial
	task automatic rel(input logic [1:0] a, input logic [7:0] d, input logic [3:0] m,
		input logic [5:0] t, input logic e);
		logic seen;
		seen = 1'h0;
		wr(a, d);
		{md, tone_req} <= {m, t};
		repeat (20)
		begin
			@(posedge clk);
			#1 seen |= line_release;
		end
		cmp(seen, e);
		@(posedge clk);
		{md, tone_req} <= 10'h000;
		repeat (10) @(posedge clk);
	endtask : rel
	task automatic t_remote();
		wr(2'h1, 8'h00);
		pulse(4'h1);
		repeat (1900 * T) @(posedge clk);
		pulse(4'h1);
		cmp(remote_id_valid, 1'h1);
		wr(2'h1, 8'h08);
		pulse(4'h1);
		repeat (1100 * T) @(posedge clk);
		pulse(4'h1);
		cmp(remote_id_valid, 1'h0);
		repeat (900 * T) @(posedge clk);
		pulse(4'h1);
		cmp(remote_id_valid, 1'h1);
	endtask : t_remote
	task automatic t_dtmf(input logic [7:0] d, input int lo, input int hi);
		wr(2'h1, d);
		tone_req <= 6'h01;
		repeat (lo * T) @(posedge clk);
		#1 cmp(dtmf_valid, 1'h0);
		repeat ((hi - lo) * T) @(posedge clk);
		#1 cmp(dtmf_valid, 1'h1);
		@(posedge clk);
		tone_req <= 6'h00;
	endtask : t_dtmf
	task automatic t_pause();
		int n;
		wr(2'h2, 8'h00);
		pulse(4'h2);
		cmp(pause_done, 1'h1);
		wr(2'h2, 8'h04);
		pulse(4'h2);
		n = 0;
		while (pause_done !== 1'h1 && n < 20000)
		begin
			@(posedge clk);
			#1 n++;
		end
		near(n, 3500 * T);
		detect_supported <= 1'h1;
		wr(2'h2, 8'h03);
		pulse(4'h2);
		cmp(pause_done, 1'h1);
	endtask : t_pause
	// second dial tone in pulse dialing: short break kept, two hits, then the wait
	task automatic t_tone();
		int n;
		wr(2'h2, 8'h43);
		pulse_dialing <= 1'h1;
		pulse(4'h2);
		tone_req <= 6'h04;
		repeat (40 * T) @(posedge clk);
		rd(2'h3, 8'h08);
		tone_req <= 6'h00;
		repeat (20 * T) @(posedge clk);
		tone_req <= 6'h04;
		repeat (20 * T) @(posedge clk);
		rd(2'h3, 8'h48);
		tone_req <= 6'h00;
		repeat (60 * T) @(posedge clk);
		tone_req <= 6'h04;
		n = 0;
		while (pause_done !== 1'h1 && n < 20000)
		begin
			@(posedge clk);
			#1 n++;
		end
		near(n, 3550 * T);
		tone_req <= 6'h00;
	endtask : t_tone
	task automatic give_verdict();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	// main sequence
	initial
	begin
		{rstn, reg_wr, reg_rd, detect_supported, recall_is_earth, pulse_dialing} = 6'h00;
		{reg_addr, reg_wdata, pl, md, tone_req} = 24'h000000;
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		t_regs();
		t_recall();
		t_dial();
		rel(2'h0, 8'h00, 4'h8, 6'h20, 1'h1);
		rel(2'h0, 8'h00, 4'h8, 6'h10, 1'h0);
		rel(2'h0, 8'h04, 4'h8, 6'h10, 1'h1);
		rel(2'h0, 8'h02, 4'h8, 6'h08, 1'h1);
		rel(2'h1, 8'h00, 4'h4, 6'h02, 1'h0);
		rel(2'h1, 8'h20, 4'h4, 6'h02, 1'h0);
		rel(2'h1, 8'h20, 4'h5, 6'h02, 1'h1);
		rel(2'h1, 8'h30, 4'h4, 6'h02, 1'h1);
		rel(2'h1, 8'h10, 4'h5, 6'h02, 1'h0);
		rel(2'h1, 8'h00, 4'h2, 6'h02, 1'h1);
		rel(2'h1, 8'h40, 4'h2, 6'h02, 1'h0);
		t_remote();
		t_dtmf(8'h00, 36, 50);
		t_dtmf(8'h80, 96, 112);
		t_pause();
		t_tone();
		give_verdict();
	end
endmodule : dls_core_tb
